// ### ppp_map.vh
// Constants for the parallel programming port: pin timing, command codes,
// load actions, back-end operation and read-space codes.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef PPP_MAP_VH
`define PPP_MAP_VH

// Clock rate and protocol times.
`define PPP_CLK_MHZ        100
`define PPP_T_LATCH_US     10
`define PPP_T_SETTLE_US    300
`define PPP_LATCH_CYCLES   (`PPP_T_LATCH_US * `PPP_CLK_MHZ)
`define PPP_SETTLE_CYCLES  (`PPP_T_SETTLE_US * `PPP_CLK_MHZ)

// Load actions selected by load_action_sel1/0.
`define PPP_ACT_ADDR       2'h0
`define PPP_ACT_DATA       2'h1
`define PPP_ACT_CMD        2'h2
`define PPP_ACT_IDLE       2'h3

// Command byte codes.
`define PPP_CMD_NOP        8'h00
`define PPP_CMD_ERASE      8'h80
`define PPP_CMD_WR_FUSE    8'h40
`define PPP_CMD_WR_LOCK    8'h20
`define PPP_CMD_WR_FLASH   8'h10
`define PPP_CMD_WR_EE      8'h11
`define PPP_CMD_RD_SIG     8'h08
`define PPP_CMD_RD_FUSE    8'h04
`define PPP_CMD_RD_FLASH   8'h02
`define PPP_CMD_RD_EE      8'h03

// Entry pattern {page_load, sel1, sel0, hilo}.
`define PPP_ENTRY_PATTERN  4'h0

// Back-end operation codes.
`define PPP_OP_PROG_FLASH  3'h0
`define PPP_OP_PROG_EE     3'h1
`define PPP_OP_FUSE        3'h2
`define PPP_OP_LOCK        3'h3
`define PPP_OP_ER_FLASH    3'h4
`define PPP_OP_ER_EE       3'h5
`define PPP_OP_ER_LOCK     3'h6

// Read spaces.
`define PPP_SP_FLASH       2'h0
`define PPP_SP_EE          2'h1
`define PPP_SP_SIG         2'h2
`define PPP_SP_FUSE        2'h3

// Pin vector reset value: write and output-enable strobes idle high.
`define PPP_PIN_RST        18'h00300

`endif

// ### ppp_fifo.v
// Small FIFO with valid/ready on both sides; width and depth are parameters.
// Assumes one clock and the asynchronous active-low reset of the port.
`timescale 1ns/100ps
`default_nettype none
module ppp_fifo #(
	parameter WIDTH = 33,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// Clock and reset.
	input  wire             core_clk,
	input  wire             rst_b,
	// Fill side.
	input  wire             in_valid,
	output reg              in_ready,
	input  wire [WIDTH-1:0] in_data,
	// Drain side.
	output reg              out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;
	wire [AW:0]     next_count;

	assign push       = in_valid & in_ready;
	assign pop        = out_valid & out_ready;
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data   = mem[rd_ptr];

	always @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Full and empty are kept as flags so both ready and valid leave flip-flops.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr    <= {AW{1'b0}};
			rd_ptr    <= {AW{1'b0}};
			count     <= {(AW+1){1'b0}};
			in_ready  <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			count     <= next_count;
			in_ready  <= (next_count != DEPTH);
			out_valid <= (next_count != {(AW+1){1'b0}});
		end
	end
endmodule // ppp_fifo
`default_nettype wire

// ### ppp_port.v
// Device-side parallel programming port for flash, EEPROM, fuse and lock bits.
// Assumes a non-volatile back end that takes one operation at a time, drains
// page-buffer words, and answers reads one cycle after a request.
`timescale 1ns/100ps
`default_nettype none
`include "ppp_map.vh"
module ppp_port #(
	parameter SETTLE_CYCLES = `PPP_SETTLE_CYCLES,
	parameter FIFO_DEPTH    = 4
) (
	// Clock and reset.
	input  wire        core_clk,
	input  wire        rst_b,
	// Programming pins.
	input  wire        load_strobe,
	input  wire        load_action_sel1,
	input  wire        load_action_sel0,
	input  wire        byte_select_hilo,
	input  wire        byte_select_ext,
	input  wire        page_load_strobe,
	input  wire        write_strobe_n,
	input  wire        output_enable_n,
	input  wire        reset_pin_hv,
	input  wire        reset_pin_low,
	input  wire [7:0]  data_in,
	output reg  [7:0]  data_out,
	output reg         data_oe,
	output reg         ready_not_busy,
	// Fuse state.
	input  wire        keep_eeprom_on_erase,
	// Mode status.
	output reg         prog_mode,
	// Back-end operations.
	output reg         nvm_op_valid,
	output reg  [2:0]  nvm_op_code,
	output reg  [15:0] nvm_op_addr,
	output reg  [15:0] nvm_op_data,
	output reg  [1:0]  nvm_op_sel,
	input  wire        nvm_op_done,
	// Back-end reads.
	output reg         nvm_rd_en,
	output reg  [1:0]  nvm_rd_space,
	output reg  [15:0] nvm_rd_addr,
	output reg  [1:0]  nvm_rd_sel,
	input  wire [7:0]  nvm_rd_data,
	// Page buffer words {is_eeprom, address, data}.
	output wire        pbuf_valid,
	input  wire        pbuf_ready,
	output wire [32:0] pbuf_data
);
	localparam ST_OFF    = 9'h001;
	localparam ST_ENTRY  = 9'h002;
	localparam ST_SETTLE = 9'h004;
	localparam ST_IDLE   = 9'h008;
	localparam ST_DRAIN  = 9'h010;
	localparam ST_EXEC   = 9'h020;
	localparam ST_ER_FL  = 9'h040;
	localparam ST_ER_EE  = 9'h080;
	localparam ST_ER_LK  = 9'h100;
	localparam integer LATCH_I = `PPP_LATCH_CYCLES, SETTLE_I = SETTLE_CYCLES;
	localparam [19:0]  LATCH_CNT = LATCH_I[19:0], SETTLE_CNT = SETTLE_I[19:0];

	// Replace one byte of a 16-bit holding register.
	function [15:0] byte_upd;
		input [15:0] old;
		input        hi;
		input [7:0]  b;
		begin
			byte_upd = hi ? {b, old[7:0]} : {old[15:8], b};
		end
	endfunction

	// Pin vector {hv, low, ld, s1, s0, hilo, ext, pgl, wr_n, oe_n, data}.
	wire [17:0] pins;
	reg  [17:0] sync1;
	reg  [17:0] sync2;
	reg  [17:0] sync3;
	reg  [17:0] filt;
	reg  [17:0] filt_d;
	assign pins = {reset_pin_hv, reset_pin_low, load_strobe, load_action_sel1,
		load_action_sel0, byte_select_hilo, byte_select_ext, page_load_strobe,
		write_strobe_n, output_enable_n, data_in};

	// A change counts only once the second and third stages agree.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1  <= `PPP_PIN_RST;
			sync2  <= `PPP_PIN_RST;
			sync3  <= `PPP_PIN_RST;
			filt   <= `PPP_PIN_RST;
			filt_d <= `PPP_PIN_RST;
		end else begin
			sync1  <= pins;
			sync2  <= sync1;
			sync3  <= sync2;
			filt   <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
			filt_d <= filt;
		end
	end

	wire       hv       = filt[17];
	wire       rst_low  = filt[16];
	wire [1:0] act      = filt[14:13];
	wire       hilo     = filt[12];
	wire       ext      = filt[11];
	wire       oe_low   = ~filt[8];
	wire [7:0] dbus     = filt[7:0];
	wire       hv_rise  = hv & ~filt_d[17];
	wire       ld_rise  = filt[15] & ~filt_d[15];
	wire       pgl_rise = filt[10] & ~filt_d[10];
	wire       wr_fall  = ~filt[9] & filt_d[9];

	reg  [8:0]  state;
	reg  [8:0]  next_state;
	reg  [19:0] timer;
	reg  [7:0]  cmd;
	reg  [15:0] addr;
	reg  [15:0] wdata;
	reg         issued;
	reg         page_open;
	wire        fifo_in_ready;
	wire        fifo_push;
	wire        is_cmd_mode;

	assign is_cmd_mode = state == ST_IDLE;
	assign fifo_push   = is_cmd_mode & pgl_rise & page_open;

	ppp_fifo #(
		.WIDTH (33),
		.DEPTH (FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.in_valid  (fifo_push),
		.in_ready  (fifo_in_ready),
		.in_data   ({cmd == `PPP_CMD_WR_EE, addr, wdata}),
		.out_valid (pbuf_valid),
		.out_ready (pbuf_ready),
		.out_data  (pbuf_data)
	);

	// Mode and operation sequencing.
	always @* begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (hv_rise) begin
					next_state = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				if (timer >= LATCH_CNT) begin
					if ({filt[10], act, hilo} == `PPP_ENTRY_PATTERN) begin
						next_state = ST_SETTLE;
					end else begin
						next_state = ST_OFF;
					end
				end
			end
			ST_SETTLE: begin
				if (timer >= SETTLE_CNT) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (wr_fall) begin
					case (cmd)
						`PPP_CMD_ERASE:    next_state = ST_ER_FL;
						`PPP_CMD_WR_FUSE:  next_state = ST_EXEC;
						`PPP_CMD_WR_LOCK:  next_state = ST_EXEC;
						`PPP_CMD_WR_FLASH: next_state = ST_DRAIN;
						`PPP_CMD_WR_EE:    next_state = ST_DRAIN;
						default:           next_state = ST_IDLE;
					endcase
				end
			end
			ST_DRAIN: begin
				// The page must be complete in the back end before it is programmed.
				if (!pbuf_valid) begin
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (issued && nvm_op_done) begin
					next_state = ST_IDLE;
				end
			end
			ST_ER_FL: begin
				if (issued && nvm_op_done) begin
					next_state = keep_eeprom_on_erase ? ST_ER_LK : ST_ER_EE;
				end
			end
			ST_ER_EE: begin
				if (issued && nvm_op_done) begin
					next_state = ST_ER_LK;
				end
			end
			ST_ER_LK: begin
				if (issued && nvm_op_done) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_OFF;
		endcase
		if (rst_low) begin
			next_state = ST_OFF;
		end
	end

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_OFF;
			timer <= 20'h00000;
		end else begin
			state <= next_state;
			timer <= (next_state != state) ? 20'h00000 : timer + 20'h00001;
		end
	end

	// Holding registers persist between operations so one load serves many.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd       <= `PPP_CMD_NOP;
			addr      <= 16'h0000;
			wdata     <= 16'h0000;
			page_open <= 1'b0;
		end else if (state == ST_OFF) begin
			cmd       <= `PPP_CMD_NOP;
			page_open <= 1'b0;
		end else if (is_cmd_mode && ld_rise) begin
			case (act)
				`PPP_ACT_ADDR: addr  <= byte_upd(addr, hilo, dbus);
				`PPP_ACT_DATA: wdata <= byte_upd(wdata, hilo, dbus);
				`PPP_ACT_CMD: begin
					cmd       <= dbus;
					// A no-operation command drops the write path.
					page_open <= (dbus == `PPP_CMD_WR_FLASH) ||
						(dbus == `PPP_CMD_WR_EE);
				end
				default: cmd <= cmd;
			endcase
		end
	end

	// Back-end operation issue; address and command are left intact.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			nvm_op_valid <= 1'b0;
			nvm_op_code  <= `PPP_OP_PROG_FLASH;
			nvm_op_addr  <= 16'h0000;
			nvm_op_data  <= 16'h0000;
			nvm_op_sel   <= 2'h0;
			issued       <= 1'b0;
		end else begin
			nvm_op_valid <= 1'b0;
			if (next_state != state) begin
				issued <= 1'b0;
			end else if (!issued && (state == ST_EXEC || state == ST_ER_FL ||
					state == ST_ER_EE || state == ST_ER_LK)) begin
				issued       <= 1'b1;
				nvm_op_valid <= 1'b1;
				nvm_op_addr  <= addr;
				nvm_op_data  <= wdata;
				nvm_op_sel   <= {ext, hilo};
				case (state)
					ST_ER_FL: nvm_op_code <= `PPP_OP_ER_FLASH;
					ST_ER_EE: nvm_op_code <= `PPP_OP_ER_EE;
					ST_ER_LK: nvm_op_code <= `PPP_OP_ER_LOCK;
					default: begin
						case (cmd)
							`PPP_CMD_WR_FUSE:  nvm_op_code <= `PPP_OP_FUSE;
							`PPP_CMD_WR_LOCK:  nvm_op_code <= `PPP_OP_LOCK;
							`PPP_CMD_WR_EE:    nvm_op_code <= `PPP_OP_PROG_EE;
							default:           nvm_op_code <= `PPP_OP_PROG_FLASH;
						endcase
					end
				endcase
			end
		end
	end

	// Reads follow output enable and start only in idle mode; the bus turns round in any programming-mode state.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			nvm_rd_en    <= 1'b0;
			nvm_rd_space <= `PPP_SP_FLASH;
			nvm_rd_addr  <= 16'h0000;
			nvm_rd_sel   <= 2'h0;
			data_out     <= 8'h00;
			data_oe      <= 1'b0;
		end else begin
			nvm_rd_en   <= 1'b0;
			nvm_rd_addr <= addr;
			nvm_rd_sel  <= {ext, hilo};
			data_oe     <= prog_mode & oe_low;
			if (is_cmd_mode && oe_low) begin
				case (cmd)
					`PPP_CMD_RD_SIG: begin
						nvm_rd_en    <= 1'b1;
						nvm_rd_space <= `PPP_SP_SIG;
					end
					`PPP_CMD_RD_FUSE: begin
						nvm_rd_en    <= 1'b1;
						nvm_rd_space <= `PPP_SP_FUSE;
					end
					`PPP_CMD_RD_FLASH: begin
						nvm_rd_en    <= 1'b1;
						nvm_rd_space <= `PPP_SP_FLASH;
					end
					`PPP_CMD_RD_EE: begin
						nvm_rd_en    <= 1'b1;
						nvm_rd_space <= `PPP_SP_EE;
					end
					default: nvm_rd_en <= 1'b0;
				endcase
			end
			if (nvm_rd_en) begin
				data_out <= nvm_rd_data;
			end
		end
	end

	// Ready also falls while the page buffer path is full, stalling page loads.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_mode      <= 1'b0;
			ready_not_busy <= 1'b0;
		end else begin
			prog_mode      <= (next_state != ST_OFF) && (next_state != ST_ENTRY);
			ready_not_busy <= (next_state == ST_IDLE) && fifo_in_ready;
		end
	end
endmodule // ppp_port
`default_nettype wire

// ### ppp_port_chk.sv
// Checker for the parallel programming port, bound to ppp_port.
// Assumes one clock and the asynchronous active-low port reset.
`timescale 1ns/100ps
`default_nettype none
`include "ppp_map.vh"
module ppp_port_chk #(
	parameter SETTLE_CYCLES = `PPP_SETTLE_CYCLES
) (
	// Clock and reset.
	input wire logic        core_clk,
	input wire logic        rst_b,
	// Pins.
	input wire logic        output_enable_n,
	input wire logic        reset_pin_low,
	input wire logic        keep_eeprom_on_erase,
	input wire logic [7:0]  data_out,
	input wire logic        data_oe,
	input wire logic        ready_not_busy,
	input wire logic        prog_mode,
	// Back end.
	input wire logic        nvm_op_valid,
	input wire logic [2:0]  nvm_op_code,
	input wire logic        nvm_op_done,
	input wire logic        nvm_rd_en,
	input wire logic [7:0]  nvm_rd_data,
	input wire logic        pbuf_valid,
	input wire logic        pbuf_ready
);
	logic [2:0]  last_code;
	logic [15:0] settle_cnt;

	// Last operation code and cycles spent in programming mode.
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_code  <= 3'h7;
			settle_cnt <= 16'h0000;
		end else begin
			if (nvm_op_valid)
				last_code <= nvm_op_code;
			if (!prog_mode)
				settle_cnt <= 16'h0000;
			else if (settle_cnt != 16'hFFFF)
				settle_cnt <= settle_cnt + 16'h0001;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	chk_oe_release: assert property (output_enable_n [*8] |-> !data_oe)
		else $error("data bus driven with output enable high");
	chk_oe_drive: assert property ((!output_enable_n && prog_mode) [*8] |-> data_oe)
		else $error("data bus not driven during a read");
	chk_busy_op: assert property (nvm_op_valid |-> !ready_not_busy)
		else $error("ready high while an operation starts");
	chk_busy_done: assert property (nvm_op_done |-> !ready_not_busy)
		else $error("ready high before operation finished");
	chk_idle_mode: assert property (!prog_mode |-> !ready_not_busy)
		else $error("ready high outside programming mode");
	chk_settle_wait: assert property (ready_not_busy |-> settle_cnt >= SETTLE_CYCLES - 1)
		else $error("ready high before settle time");
	chk_exit_low: assert property (reset_pin_low [*8] |-> !prog_mode)
		else $error("programming mode kept with reset pin low");
	chk_ee_order: assert property (nvm_op_valid && nvm_op_code == `PPP_OP_ER_EE
		|-> last_code == `PPP_OP_ER_FLASH && !keep_eeprom_on_erase)
		else $error("eeprom erase out of order or not wanted");
	chk_lock_last: assert property (nvm_op_valid && nvm_op_code == `PPP_OP_ER_LOCK
		|-> last_code == (keep_eeprom_on_erase ? `PPP_OP_ER_FLASH : `PPP_OP_ER_EE))
		else $error("lock bits erased before memories");
	chk_read_data: assert property (nvm_rd_en |-> ##2 data_out == $past(nvm_rd_data))
		else $error("read byte not passed to the data bus");

	cov_erase: cover property (nvm_op_valid && nvm_op_code == `PPP_OP_ER_LOCK);
	cov_stall: cover property (pbuf_valid && !pbuf_ready [*3]);
	cov_read: cover property (nvm_rd_en ##1 data_oe);
endmodule // ppp_port_chk
`default_nettype wire

// ### ppp_nvm_model.sv
// Back-end model behind the port: answers operations, reads and page words.
// Assumes the port's one-cycle request pulses; stall holds off page words.
`timescale 1ns/100ps
`default_nettype none
module ppp_nvm_model (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// Operations.
	input  wire logic        nvm_op_valid,
	input  wire logic [2:0]  nvm_op_code,
	output var  logic        nvm_op_done,
	// Reads.
	input  wire logic        nvm_rd_en,
	input  wire logic [1:0]  nvm_rd_space,
	input  wire logic [15:0] nvm_rd_addr,
	input  wire logic [1:0]  nvm_rd_sel,
	output var  logic [7:0]  nvm_rd_data,
	// Page words.
	input  wire logic        pbuf_valid,
	output var  logic        pbuf_ready,
	input  wire logic [32:0] pbuf_data,
	input  wire logic        stall,
	// Observation.
	output var  logic [8:0]  op_log,
	output var  logic [7:0]  op_cnt,
	output var  logic [7:0]  pb_cnt,
	output var  logic [32:0] pb_last
);
	logic [5:0] wait_cnt;
	logic       busy;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{nvm_op_done, pbuf_ready, busy, wait_cnt, op_log} <= '0;
			{op_cnt, pb_cnt, pb_last, nvm_rd_data} <= '0;
		end else begin
			nvm_op_done <= 1'b0;
			// Half-rate acceptance, so the page buffer never drains in one burst.
			pbuf_ready <= !stall && !pbuf_ready;
			if (nvm_op_valid) begin
				busy     <= 1'b1;
				wait_cnt <= op_cnt[0] ? 6'h14 : 6'h01;
				op_log   <= {op_log[5:0], nvm_op_code};
				op_cnt   <= op_cnt + 8'h01;
			end else if (busy) begin
				if (wait_cnt == 6'h00) begin
					busy        <= 1'b0;
					nvm_op_done <= 1'b1;
				end else
					wait_cnt <= wait_cnt - 6'h01;
			end
			if (pbuf_valid && pbuf_ready) begin
				pb_cnt  <= pb_cnt + 8'h01;
				pb_last <= pbuf_data;
			end
			// Outside a read the byte keeps changing, so stale data cannot match.
			if (nvm_rd_en)
				nvm_rd_data <= nvm_rd_addr[7:0] ^ {nvm_rd_space, 4'h0, nvm_rd_sel};
			else
				nvm_rd_data <= ~nvm_rd_data;
		end
	end
endmodule // ppp_nvm_model
`default_nettype wire

// ### tb_ppp_port.sv
// Self-checking bench for the parallel programming port with a back-end model.
// Assumes ppp_port, ppp_fifo, ppp_nvm_model and ppp_port_chk are compiled.
`timescale 1ns/100ps
`default_nettype none
`include "ppp_map.vh"
module tb_ppp_port;
	logic core_clk, rst_b, load_strobe, load_action_sel1, load_action_sel0, byte_select_hilo;
	logic byte_select_ext, page_load_strobe, write_strobe_n, output_enable_n, reset_pin_hv;
	logic reset_pin_low, keep_eeprom_on_erase, stall, data_oe, ready_not_busy, prog_mode;
	logic nvm_op_valid, nvm_op_done, nvm_rd_en, pbuf_valid, pbuf_ready;
	logic [7:0]  data_in, data_out, nvm_rd_data, op_cnt, pb_cnt, n;
	logic [2:0]  nvm_op_code;
	logic [1:0]  nvm_op_sel, nvm_rd_space, nvm_rd_sel;
	logic [15:0] nvm_op_addr, nvm_op_data, nvm_rd_addr;
	logic [32:0] pbuf_data, pb_last;
	logic [8:0]  op_log;
	logic [7:0]  rd_cmd [4] = '{`PPP_CMD_RD_SIG, `PPP_CMD_RD_FUSE, `PPP_CMD_RD_FLASH, `PPP_CMD_RD_EE};
	logic [1:0]  rd_sp [4] = '{`PPP_SP_SIG, `PPP_SP_FUSE, `PPP_SP_FLASH, `PPP_SP_EE};
	int n_mismatch = 0;
	int n_compared = 0;

	ppp_port #(.SETTLE_CYCLES(50)) ppp_port_inst (.*);
	ppp_nvm_model ppp_nvm_model_inst (.*);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic step(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_rdy;
		int i;
		for (i = 0; i < 3000 && ready_not_busy !== 1'b1; i++)
			step(1);
		if (i == 3000) begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	// Pulses stay well above the 2-cycle minimum so the pin filter always sees them.
	task automatic load(input logic [1:0] act, input logic hi, ext, input logic [7:0] b);
		{load_action_sel1, load_action_sel0} = act;
		{byte_select_hilo, byte_select_ext} = {hi, ext};
		data_in = b;
		step(10);
		load_strobe = 1'b1;
		step(30);
		load_strobe = 1'b0;
		step(10);
	endtask
	task automatic pulse_pl;
		page_load_strobe = 1'b1;
		step(30);
		page_load_strobe = 1'b0;
		step(10);
	endtask
	task automatic wr;
		write_strobe_n = 1'b0;
		step(30);
		write_strobe_n = 1'b1;
		step(10);
		wait_rdy;
	endtask
	task automatic rd(input logic hi, ext, input logic [7:0] exp, input logic [1:0] sp);
		{byte_select_hilo, byte_select_ext} = {hi, ext};
		step(5);
		output_enable_n = 1'b0;
		step(30);
		chk("data_oe", data_oe, 1);
		chk("rd_space", nvm_rd_space, sp);
		chk("rd_sel", nvm_rd_sel, {ext, hi});
		chk("rd_addr", nvm_rd_addr, 16'h5634);
		chk("data_out", data_out, exp);
		output_enable_n = 1'b1;
		step(15);
	endtask

	initial begin
		{rst_b, load_strobe, load_action_sel1, load_action_sel0, byte_select_hilo} = '0;
		{byte_select_ext, page_load_strobe, reset_pin_hv, reset_pin_low} = '0;
		{keep_eeprom_on_erase, stall, data_in} = '0;
		{write_strobe_n, output_enable_n} = 2'b11;
		step(5);
		rst_b = 1'b1;
		step(2);
		reset_pin_hv = 1'b1;
		step(900);
		chk("ready_early", ready_not_busy, 0);
		wait_rdy;
		chk("prog_mode", prog_mode, 1);
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_ERASE);
		wr;
		// Fill the page buffer with the back end stalled, then let it drain.
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_WR_FLASH);
		load(`PPP_ACT_ADDR, 1, 0, 8'h12);
		load(`PPP_ACT_DATA, 1, 0, 8'hAB);
		stall = 1'b1;
		for (int i = 0; i < 4; i++) begin
			load(`PPP_ACT_ADDR, 0, 0, 8'(i));
			load(`PPP_ACT_DATA, 0, 0, 8'(i) + 8'h40);
			pulse_pl;
		end
		chk("ready_full", ready_not_busy, 0);
		chk("pb_stalled", pb_cnt, 0);
		stall = 1'b0;
		wait_rdy;
		// Ready returns after the first word leaves, so let the rest drain.
		step(20);
		chk("pb_cnt", pb_cnt, 4);
		chk("pb_last", pb_last, {1'b0, 16'h1203, 16'hAB43});
		wr;
		chk("op_flash", {op_cnt, op_log[2:0]}, {8'h04, `PPP_OP_PROG_FLASH});
		chk("op_addr", nvm_op_addr, 16'h1203);
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_WR_EE);
		pulse_pl;
		wr;
		chk("op_ee", op_log[2:0], `PPP_OP_PROG_EE);
		chk("pb_ee", pb_last[32], 1);
		load(`PPP_ACT_CMD, 0, 1, `PPP_CMD_WR_FUSE);
		load(`PPP_ACT_DATA, 0, 1, 8'h5A);
		wr;
		chk("op_fuse", op_log[2:0], `PPP_OP_FUSE);
		chk("fuse_data", nvm_op_data[7:0], 8'h5A);
		chk("fuse_sel", nvm_op_sel, 2'b10);
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_WR_LOCK);
		wr;
		load(`PPP_ACT_IDLE, 0, 0, `PPP_CMD_ERASE);
		wr;
		chk("op_lock", op_log[5:0], {`PPP_OP_LOCK, `PPP_OP_LOCK});
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_NOP);
		n = op_cnt;
		wr;
		chk("nop_cnt", op_cnt, n);
		load(`PPP_ACT_CMD, 0, 0, `PPP_CMD_ERASE);
		wr;
		chk("erase", op_log, {`PPP_OP_ER_FLASH, `PPP_OP_ER_EE, `PPP_OP_ER_LOCK});
		keep_eeprom_on_erase = 1'b1;
		n = op_cnt;
		wr;
		chk("keep_cnt", op_cnt, n + 8'h02);
		chk("keep_ops", op_log[5:0], {`PPP_OP_ER_FLASH, `PPP_OP_ER_LOCK});
		load(`PPP_ACT_ADDR, 1, 0, 8'h56);
		load(`PPP_ACT_ADDR, 0, 0, 8'h34);
		for (int i = 0; i < 4; i++) begin
			load(`PPP_ACT_CMD, 0, 0, rd_cmd[i]);
			rd(i[0], i[1], 8'h34 ^ {rd_sp[i], 4'h0, i[1], i[0]}, rd_sp[i]);
		end
		reset_pin_low = 1'b1;
		step(10);
		chk("exit_mode", prog_mode, 0);
		chk("exit_ready", ready_not_busy, 0);
		// A wrong entry pattern under high voltage must not enter the mode.
		{reset_pin_low, reset_pin_hv, load_action_sel1, load_action_sel0} = 4'b0001;
		step(10);
		reset_pin_hv = 1'b1;
		step(1100);
		chk("bad_entry", prog_mode, 0);
		print_verdict;
	end
endmodule // tb_ppp_port

bind ppp_port ppp_port_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) ppp_port_chk_inst (.*);
`default_nettype wire
